// file: pkg/ckctl_pkg.sv
// Constants shared by the clock source, PLL and fail-safe control block
package ckctl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OSC_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] AUX_CTRL_OFS = 4'h4;

  // Oscillator control field positions
  localparam int TRIM_HI_LSB = 14;
  localparam int CUR_GRP_LSB = 12;
  localparam int TRIM_LO_LSB = 10;
  localparam int NEW_GRP_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CFAIL_BIT = 3;
  localparam int SWREQ_BIT = 0;

  // Auxiliary control and status bit positions
  localparam int WD_SOFT_BIT = 0;
  localparam int SW_BUSY_BIT = 1;
  localparam int SLOW_ON_BIT = 2;
  localparam int CLK_HOLD_BIT = 3;
  localparam int MON_ON_BIT = 4;

  // Values after reset
  localparam logic [3:0] TRIM_RESET = 4'h0;
  localparam logic WD_SOFT_RESET = 1'b0;

  // Clock groups
  localparam logic [1:0] GRP_SECONDARY = 2'h0;
  localparam logic [1:0] GRP_FAST_RC = 2'h1;
  localparam logic [1:0] GRP_SLOW_RC = 2'h2;
  localparam logic [1:0] GRP_PRIMARY = 2'h3;

  // Unlock key bytes
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9A;

  // Primary mode codes running the PLL from the fast RC oscillator
  localparam logic [3:0] FPR_FRC_X4 = 4'h1;
  localparam logic [3:0] FPR_FRC_X8 = 4'hA;
  localparam logic [3:0] FPR_FRC_X16 = 4'h3;

  // Switch and monitor fuse codes
  localparam logic [1:0] FCK_BOTH_ON = 2'h0;

  // PLL multiplier encoding
  localparam logic [1:0] PLL_OFF = 2'h0;
  localparam logic [1:0] PLL_X4 = 2'h1;
  localparam logic [1:0] PLL_X8 = 2'h2;
  localparam logic [1:0] PLL_X16 = 2'h3;
endpackage : ckctl_pkg

// file: rtl/ckctl_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs
module ckctl_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic [W-1:0] dIn,
  output logic [W-1:0] dOut
);
  logic [W-1:0] metaQ;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      metaQ <= '0;
      dOut <= '0;
    end else begin
      metaQ <= dIn;
      dOut <= metaQ;
    end
  end
endmodule : ckctl_sync

// file: rtl/ckctl_top.sv
// Clock source selection, PLL control, fast RC trim and fail-safe monitor
// What this block does
// - PLL multiplies primary or fast RC by 4/8/16
// - Lock bit follows PLL lock, read only
// - Current group 01 runs from fast RC
// - Four-bit split trim field, 1.5% steps
// - Group 11 with fast RC codes picks multiplier
// - Slow RC on at power-on, then conditionally
// - Slow RC clocks timer, watchdog and monitor
// - Monitor on keeps slow RC running except Sleep
// - Failure: trap, fast RC, set flag, clear request
// - Clock failure leaves the watchdog untouched
// - Timer expiry before oscillator start traps
// - Switch only between groups; fuses pick primary
// - Current group read only, new group writable
// - Power-on or brown-out loads both group fields
// - Request bit starts switch; clearing it aborts
// - Fuses 1x disable switching and monitoring
// - Switching off: fuses choose, field just reports
// - Byte lanes write only after two key writes
// - Lock at bit 5; clock held after brown-out when group 11 uses the PLL
module ckctl_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ckctl_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ckctl_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ckctl_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic porEvent,
  input wire logic borEvent,
  input wire logic pwrtExpired,
  input wire logic sleepMode,
  input wire logic oscFailDetect,
  input wire logic pllLockRaw,
  input wire logic [3:0] sourceReady,
  input wire logic [1:0] groupSelectFuses,
  input wire logic [3:0] primaryModeFuses,
  input wire logic [1:0] switchMonitorFuses,
  input wire logic watchdogFuseEnable,
  output logic [1:0] sysClkGroup,
  output logic [3:0] sourceEnable,
  output logic [1:0] pllMult,
  output logic pllFromFastRc,
  output logic [3:0] fastRcTrim,
  output logic slowRcEnable,
  output logic watchdogRun,
  output logic clockFailTrap,
  output logic sysClkHold
);
  import ckctl_pkg::*;

  typedef enum logic {SW_IDLE, SW_WAIT} ckctl_sw_state_t;

  localparam int SYNC_W = 19;

  // Decodes the PLL use of a primary mode code: {from fast RC, multiplier}
  function automatic logic [2:0] pllDecode(input logic [3:0] mode);
    logic [2:0] res;
    res = {1'b0, PLL_OFF};
    if (mode == FPR_FRC_X4) begin
      res = {1'b1, PLL_X4};
    end else if (mode == FPR_FRC_X8) begin
      res = {1'b1, PLL_X8};
    end else if (mode == FPR_FRC_X16) begin
      res = {1'b1, PLL_X16};
    end else if (mode[2] && mode[1:0] != 2'h0) begin
      res = {1'b0, mode[1:0]};
    end
    return res;
  endfunction : pllDecode

  function automatic logic [3:0] groupOneHot(input logic [1:0] grp);
    logic [3:0] res;
    res = 4'h0;
    res[grp] = 1'b1;
    return res;
  endfunction : groupOneHot

  logic rstMetaQ;
  logic rstN;
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic porS;
  logic borS;
  logic pwrtS;
  logic sleepS;
  logic oscFailS;
  logic lockS;
  logic [3:0] readyS;
  logic [1:0] fosS;
  logic [3:0] fprS;
  logic [1:0] fckS;
  logic wdFuseS;

  // Reset released through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaQ <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstN <= rstMetaQ;
    end
  end

  assign syncIn = {porEvent, borEvent, pwrtExpired, sleepMode, oscFailDetect, pllLockRaw,
                   sourceReady, groupSelectFuses, primaryModeFuses, switchMonitorFuses,
                   watchdogFuseEnable};

  ckctl_sync #(.W(SYNC_W)) uInSync (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .dIn(syncIn),
    .dOut(syncOut)
  );

  assign {porS, borS, pwrtS, sleepS, oscFailS, lockS, readyS, fosS, fprS, fckS, wdFuseS} = syncOut;

  // Bus slave: one wait state, then the request is taken
  logic ackQ;
  logic busReq;
  logic accept;
  logic wrOsc;
  logic wrAux;
  logic loOpen;
  logic hiOpen;
  logic wrLo;
  logic wrHi;

  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ackQ;
  assign accept = busReq & ackQ;
  assign wrOsc = accept & avs_write & (avs_address == OSC_CTRL_OFS);
  assign wrAux = accept & avs_write & (avs_address == AUX_CTRL_OFS) & avs_byteenable[0];

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busReq & ~ackQ;
    end
  end

  ckctl_unlock #(.KEY1(KEY_LO_1), .KEY2(KEY_LO_2)) uLoUnlock (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .anyAccept(accept),
    .laneWrite(wrOsc & avs_byteenable[0]),
    .laneData(avs_writedata[7:0]),
    .laneOpen(loOpen)
  );

  ckctl_unlock #(.KEY1(KEY_HI_1), .KEY2(KEY_HI_2)) uHiUnlock (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .anyAccept(accept),
    .laneWrite(wrOsc & avs_byteenable[1]),
    .laneData(avs_writedata[15:8]),
    .laneOpen(hiOpen)
  );

  assign wrLo = wrOsc & avs_byteenable[0] & loOpen;
  assign wrHi = wrOsc & avs_byteenable[1] & hiOpen;

  // Oscillator and monitor state
  logic [1:0] curGroupQ;
  logic [1:0] newGroupQ;
  logic [3:0] trimQ;
  logic clockFailQ;
  logic swReqQ;
  logic wdSoftQ;
  logic pwrtDlyQ;
  logic failDlyQ;
  logic holdQ;
  ckctl_sw_state_t swStateQ;

  logic resetLoad;
  logic switchEn;
  logic monitorFuse;
  logic monitorOn;
  logic [1:0] effGroup;
  logic [2:0] pllInfo;
  logic pllUsed;
  logic curReady;
  logic newReady;
  logic failEvent;
  logic swStart;
  logic swDone;
  logic slowRcOn;

  assign resetLoad = porS | borS;
  assign switchEn = ~fckS[1];
  assign monitorFuse = (fckS == FCK_BOTH_ON);
  assign monitorOn = monitorFuse & ~sleepS;
  assign effGroup = switchEn ? curGroupQ : fosS;
  assign pllInfo = pllDecode(fprS);
  assign pllUsed = (effGroup == GRP_PRIMARY) && (pllInfo[1:0] != PLL_OFF);

  // A primary source using the PLL is ready only once locked
  assign curReady = readyS[curGroupQ] & ((curGroupQ != GRP_PRIMARY) | ~pllUsed | lockS);
  assign newReady = readyS[newGroupQ] & ((newGroupQ != GRP_PRIMARY) | (pllInfo[1:0] == PLL_OFF) | lockS);

  // Failure seen by the monitor, or start-up not done when the timer ends
  assign failEvent = monitorOn & ((oscFailS & ~failDlyQ) | (pwrtS & ~pwrtDlyQ & ~curReady));

  assign swStart = switchEn & (swStateQ == SW_IDLE) & swReqQ;
  assign swDone = (swStateQ == SW_WAIT) & swReqQ & newReady;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pwrtDlyQ <= 1'b0;
      failDlyQ <= 1'b0;
    end else begin
      pwrtDlyQ <= pwrtS;
      failDlyQ <= oscFailS;
    end
  end

  // Current group: loaded by reset events, switches and failures
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      curGroupQ <= GRP_FAST_RC;
    end else if (resetLoad) begin
      curGroupQ <= fosS;
    end else if (failEvent) begin
      curGroupQ <= GRP_FAST_RC;
    end else if (swDone) begin
      curGroupQ <= newGroupQ;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      newGroupQ <= GRP_FAST_RC;
    end else if (resetLoad) begin
      newGroupQ <= fosS;
    end else if (wrHi) begin
      newGroupQ <= avs_writedata[NEW_GRP_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      trimQ <= TRIM_RESET;
    end else if (resetLoad) begin
      trimQ <= TRIM_RESET;
    end else if (wrHi) begin
      trimQ <= {avs_writedata[TRIM_HI_LSB +: 2], avs_writedata[TRIM_LO_LSB +: 2]};
    end
  end

  // Failure flag: a new failure wins over a software clear
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      clockFailQ <= 1'b0;
    end else if (failEvent) begin
      clockFailQ <= 1'b1;
    end else if (resetLoad) begin
      clockFailQ <= 1'b0;
    end else if (wrLo && !avs_writedata[CFAIL_BIT]) begin
      clockFailQ <= 1'b0;
    end
  end

  // Switch request: set by software, cleared on completion or failure
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      swReqQ <= 1'b0;
    end else if (resetLoad || failEvent || swDone) begin
      swReqQ <= 1'b0;
    end else if (wrLo) begin
      swReqQ <= avs_writedata[SWREQ_BIT] & switchEn;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      swStateQ <= SW_IDLE;
    end else if (resetLoad || failEvent) begin
      swStateQ <= SW_IDLE;
    end else begin
      unique case (swStateQ)
        SW_IDLE: begin
          if (swStart) begin
            swStateQ <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (!swReqQ || swDone) begin
            swStateQ <= SW_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wdSoftQ <= WD_SOFT_RESET;
    end else if (wrAux) begin
      wdSoftQ <= avs_writedata[WD_SOFT_BIT];
    end
  end

  // Clock withheld after brown-out, when group 11 uses the PLL, until the PLL locks
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      holdQ <= 1'b0;
    end else if (borS && pllUsed) begin
      holdQ <= 1'b1;
    end else if (lockS) begin
      holdQ <= 1'b0;
    end
  end

  // Slow RC: on until the power-up timer ends, then only when needed
  assign slowRcOn = ~pwrtS | monitorOn | (wdFuseS | wdSoftQ) | (effGroup == GRP_SLOW_RC);

  // Outputs from flip-flops
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      sysClkGroup <= GRP_FAST_RC;
      sourceEnable <= 4'h0;
      pllMult <= PLL_OFF;
      pllFromFastRc <= 1'b0;
      fastRcTrim <= TRIM_RESET;
      slowRcEnable <= 1'b1;
      watchdogRun <= 1'b0;
      clockFailTrap <= 1'b0;
      sysClkHold <= 1'b1;
    end else begin
      sysClkGroup <= effGroup;
      sourceEnable <= groupOneHot(effGroup)
                      | ((swStateQ == SW_WAIT) ? groupOneHot(newGroupQ) : 4'h0)
                      | {1'b0, slowRcOn, 2'h0};
      pllMult <= pllUsed ? pllInfo[1:0] : PLL_OFF;
      pllFromFastRc <= pllUsed & pllInfo[2];
      fastRcTrim <= trimQ;
      slowRcEnable <= slowRcOn;
      watchdogRun <= wdFuseS | wdSoftQ;
      clockFailTrap <= failEvent;
      sysClkHold <= holdQ | (borS & pllUsed);
    end
  end

  // Register read
  logic [15:0] oscWord;
  logic [15:0] auxWord;

  always_comb begin
    oscWord = 16'h0000;
    oscWord[TRIM_HI_LSB +: 2] = trimQ[3:2];
    oscWord[CUR_GRP_LSB +: 2] = effGroup;
    oscWord[TRIM_LO_LSB +: 2] = trimQ[1:0];
    oscWord[NEW_GRP_LSB +: 2] = newGroupQ;
    oscWord[LOCK_BIT] = lockS;
    oscWord[CFAIL_BIT] = clockFailQ;
    oscWord[SWREQ_BIT] = swReqQ;
  end

  always_comb begin
    auxWord = 16'h0000;
    auxWord[WD_SOFT_BIT] = wdSoftQ;
    auxWord[SW_BUSY_BIT] = (swStateQ == SW_WAIT);
    auxWord[SLOW_ON_BIT] = slowRcOn;
    auxWord[CLK_HOLD_BIT] = holdQ;
    auxWord[MON_ON_BIT] = monitorOn;
  end

  // Read data captured one edge before the request is taken
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      avs_readdata <= '0;
    end else if (avs_read && !ackQ) begin
      if (avs_address == OSC_CTRL_OFS) begin
        avs_readdata <= {16'h0000, oscWord};
      end else if (avs_address == AUX_CTRL_OFS) begin
        avs_readdata <= {16'h0000, auxWord};
      end else begin
        avs_readdata <= '0;
      end
    end
  end
endmodule : ckctl_top

// file: rtl/ckctl_unlock.sv
// Two-key unlock for one byte lane of the oscillator control register
module ckctl_unlock #(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic anyAccept,
  input wire logic laneWrite,
  input wire logic [7:0] laneData,
  output logic laneOpen
);
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} ckctl_ul_state_t;
  ckctl_ul_state_t stateQ;

  assign laneOpen = (stateQ == UL_OPEN);

  // Any access between keys or after opening closes the lane
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      stateQ <= UL_IDLE;
    end else if (anyAccept) begin
      unique case (stateQ)
        UL_IDLE: stateQ <= (laneWrite && laneData == KEY1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1: stateQ <= (laneWrite && laneData == KEY2) ? UL_OPEN
                           : (laneWrite && laneData == KEY1) ? UL_KEY1 : UL_IDLE;
        UL_OPEN: stateQ <= UL_IDLE;
        default: stateQ <= UL_IDLE;
      endcase
    end
  end
endmodule : ckctl_unlock

// file: verification/ckctl_top_assertions.sv
// Bus handshake and fail-safe checks for the clock control block
module ckctl_top_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [ckctl_pkg::DATA_W-1:0] avs_readdata,
  input wire logic oscFailDetect,
  input wire logic sleepMode,
  input wire logic [1:0] switchMonitorFuses,
  input wire logic pwrtExpired,
  input wire logic [1:0] sysClkGroup,
  input wire logic [1:0] pllMult,
  input wire logic slowRcEnable,
  input wire logic watchdogRun,
  input wire logic clockFailTrap
);
  import ckctl_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not exactly one cycle");
  chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_trap_pulse: assert property (clockFailTrap |=> !clockFailTrap)
    else $error("trap longer than one cycle");
  chk_trap_frc: assert property (clockFailTrap |=> sysClkGroup == GRP_FAST_RC)
    else $error("trap without fast RC group");
  chk_fail_trap: assert property ($rose(oscFailDetect) && switchMonitorFuses == FCK_BOTH_ON && !sleepMode
    |-> ##[2:6] clockFailTrap)
    else $error("failure raised no trap");
  chk_wd_steady: assert property (clockFailTrap |-> $stable(watchdogRun))
    else $error("watchdog disturbed by failure");
  chk_slow_powerup_timer: assert property (!pwrtExpired [*4] |-> slowRcEnable)
    else $error("slow RC off before timer expiry");
  chk_pll_grp: assert property ($past(sysClkGroup) != GRP_PRIMARY && sysClkGroup != GRP_PRIMARY
    |-> pllMult == PLL_OFF)
    else $error("PLL on outside primary group");
  chk_no_mon: assert property (switchMonitorFuses[1] [*6] |-> !clockFailTrap)
    else $error("trap with monitor disabled");
  cover property (clockFailTrap);
  cover property (avs_read && !avs_waitrequest);
  cover property ($changed(sysClkGroup));
endmodule : ckctl_top_chk

bind ckctl_top ckctl_top_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .oscFailDetect(oscFailDetect), .sleepMode(sleepMode), .switchMonitorFuses(switchMonitorFuses),
  .pwrtExpired(pwrtExpired), .sysClkGroup(sysClkGroup), .pllMult(pllMult), .slowRcEnable(slowRcEnable),
  .watchdogRun(watchdogRun), .clockFailTrap(clockFailTrap));

// file: verification/tb_ckctl_top.sv
// Register-level testbench of the clock control block
module tb_ckctl_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ckctl_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, porEvent = 1'b0;
  logic borEvent = 1'b0, pwrtExpired = 1'b0, sleepMode = 1'b0, oscFailDetect = 1'b0, pllLockRaw = 1'b0;
  logic watchdogFuseEnable = 1'b0, avs_waitrequest, pllFromFastRc, slowRcEnable, watchdogRun;
  logic clockFailTrap, sysClkHold;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0, sourceReady = 4'hF, primaryModeFuses = FPR_FRC_X8;
  logic [3:0] sourceEnable, fastRcTrim;
  logic [1:0] groupSelectFuses = GRP_PRIMARY, switchMonitorFuses = FCK_BOTH_ON, sysClkGroup, pllMult;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  int numErrors = 0, nCompared = 0, cyc = 0;
  localparam logic [3:0] MODES [3] = '{FPR_FRC_X4, FPR_FRC_X8, FPR_FRC_X16};

  ckctl_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .porEvent(porEvent),
    .borEvent(borEvent), .pwrtExpired(pwrtExpired), .sleepMode(sleepMode), .oscFailDetect(oscFailDetect),
    .pllLockRaw(pllLockRaw), .sourceReady(sourceReady), .groupSelectFuses(groupSelectFuses),
    .primaryModeFuses(primaryModeFuses), .switchMonitorFuses(switchMonitorFuses),
    .watchdogFuseEnable(watchdogFuseEnable), .sysClkGroup(sysClkGroup), .sourceEnable(sourceEnable),
    .pllMult(pllMult), .pllFromFastRc(pllFromFastRc), .fastRcTrim(fastRcTrim), .slowRcEnable(slowRcEnable),
    .watchdogRun(watchdogRun), .clockFailTrap(clockFailTrap), .sysClkHold(sysClkHold));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      numErrors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    nCompared++;
    if (act !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic isRd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= isRd;
    avs_write <= !isRd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0, 4'hF);
  endtask : rd

  task automatic hi(input logic [7:0] v);
    bus(1'b0, OSC_CTRL_OFS, {16'h0, v, 8'h00}, 4'h2);
  endtask : hi

  task automatic lk(input logic [7:0] v);
    bus(1'b0, OSC_CTRL_OFS, {24'h0, KEY_LO_1}, 4'h1);
    bus(1'b0, OSC_CTRL_OFS, {24'h0, KEY_LO_2}, 4'h1);
    bus(1'b0, OSC_CTRL_OFS, {24'h0, v}, 4'h1);
    tick(2);
  endtask : lk

  task automatic hk(input logic [7:0] v);
    hi(KEY_HI_1);
    hi(KEY_HI_2);
    hi(v);
    tick(2);
  endtask : hk

  initial begin
    tick(16);
    chk("hold", 1, sysClkHold);
    chk("slowrc", 1, slowRcEnable);
    chk("mult", PLL_OFF, pllMult);
    reset_n <= 1'b1;
    tick(4);
    porEvent <= 1'b1;
    tick(2);
    porEvent <= 1'b0;
    tick(6);
    rd(OSC_CTRL_OFS);
    chk("cur", GRP_PRIMARY, rdat[13:12]);
    chk("new", GRP_PRIMARY, rdat[9:8]);
    chk("sysgrp", GRP_PRIMARY, sysClkGroup);
    for (int i = 0; i < 3; i++) begin
      primaryModeFuses <= MODES[i];
      tick(6);
      chk("mult", i + 1, pllMult);
      chk("frc", 1, pllFromFastRc);
    end
    primaryModeFuses <= FPR_FRC_X8;
    pllLockRaw <= 1'b1;
    tick(6);
    rd(OSC_CTRL_OFS);
    chk("lock", 1, rdat[LOCK_BIT]);
    chk("hold", 0, sysClkHold);
    pllLockRaw <= 1'b0;
    borEvent <= 1'b1;
    tick(3);
    borEvent <= 1'b0;
    tick(6);
    chk("hold", 1, sysClkHold);
    rd(OSC_CTRL_OFS);
    chk("lock", 0, rdat[LOCK_BIT]);
    pllLockRaw <= 1'b1;
    tick(6);
    chk("hold", 0, sysClkHold);
    $display("test reset and lock done");
    hi(8'h81);
    tick(2);
    chk("trim", 0, fastRcTrim);
    hk(8'h4D);
    chk("trim", 4'h7, fastRcTrim);
    hk(8'h81);
    chk("trim", 4'h8, fastRcTrim);
    rd(OSC_CTRL_OFS);
    chk("new", GRP_FAST_RC, rdat[9:8]);
    chk("cur", GRP_PRIMARY, rdat[13:12]);
    lk(8'h01);
    tick(6);
    chk("sysgrp", GRP_FAST_RC, sysClkGroup);
    rd(OSC_CTRL_OFS);
    chk("swreq", 0, rdat[SWREQ_BIT]);
    $display("test trim and switch done");
    sourceReady <= 4'hB;
    hk(8'h82);
    lk(8'h01);
    tick(4);
    rd(AUX_CTRL_OFS);
    chk("busy", 1, rdat[SW_BUSY_BIT]);
    lk(8'h00);
    rd(AUX_CTRL_OFS);
    chk("busy", 0, rdat[SW_BUSY_BIT]);
    sourceReady <= 4'hF;
    tick(6);
    chk("sysgrp", GRP_FAST_RC, sysClkGroup);
    $display("test abort done");
    hk(8'h83);
    lk(8'h01);
    tick(6);
    chk("sysgrp", GRP_PRIMARY, sysClkGroup);
    chk("srcen", 4'hC, sourceEnable);
    bus(1'b0, AUX_CTRL_OFS, 32'h1, 4'h1);
    sourceReady <= 4'hB;
    hk(8'h82);
    lk(8'h01);
    oscFailDetect <= 1'b1;
    tick(8);
    chk("sysgrp", GRP_FAST_RC, sysClkGroup);
    chk("wdrun", 1, watchdogRun);
    rd(OSC_CTRL_OFS);
    chk("cfail", 1, rdat[CFAIL_BIT]);
    chk("swreq", 0, rdat[SWREQ_BIT]);
    oscFailDetect <= 1'b0;
    lk(8'h00);
    rd(OSC_CTRL_OFS);
    chk("cfail", 0, rdat[CFAIL_BIT]);
    $display("test clock failure done");
    bus(1'b0, AUX_CTRL_OFS, 32'h0, 4'h1);
    sourceReady <= 4'h9;
    pwrtExpired <= 1'b1;
    tick(8);
    rd(OSC_CTRL_OFS);
    chk("cfail", 1, rdat[CFAIL_BIT]);
    chk("sysgrp", GRP_FAST_RC, sysClkGroup);
    chk("slowrc", 1, slowRcEnable);
    sleepMode <= 1'b1;
    tick(6);
    chk("slowrc", 0, slowRcEnable);
    sleepMode <= 1'b0;
    lk(8'h00);
    sourceReady <= 4'hF;
    switchMonitorFuses <= 2'h2;
    tick(6);
    chk("slowrc", 0, slowRcEnable);
    chk("sysgrp", GRP_PRIMARY, sysClkGroup);
    lk(8'h01);
    oscFailDetect <= 1'b1;
    tick(8);
    rd(OSC_CTRL_OFS);
    chk("swreq", 0, rdat[SWREQ_BIT]);
    chk("cfail", 0, rdat[CFAIL_BIT]);
    chk("cur", GRP_PRIMARY, rdat[13:12]);
    bus(1'b0, 4'h8, 32'hFFFFFFFF, 4'hF);
    rd(4'h8);
    chk("unmapped", 0, rdat);
    $display("test fuses off done");
    complete_run();
  end
endmodule : tb_ckctl_top
